// [strr_checker_model.sv]
`timescale 1ns/1ps
`default_nettype none
// subtest checkers on the far side of the request port
module strr_checker_model (
    input  wire logic                       mclk,
    input  wire logic                       rstn,
    input  wire strr_pkg::strr_subreq_type  sub_req,
    input  wire logic [9:0]                 fail_mask,
    input  wire logic                       slow,
    output logic                            sub_done,
    output logic                            sub_fail,
    output var int                          served,
    output var int                          drive_cnt
);
    int wait_cnt; // cycles left before the next answer

    // answer each request once; fail line toggles while not qualified
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sub_done  <= 1'b0;
            sub_fail  <= 1'b0;
            wait_cnt  <= 0;
            served    <= 0;
            drive_cnt <= 0;
        end else begin
            sub_done <= 1'b0;
            sub_fail <= ~sub_fail;
            // output driven by the checker: only legal after clean digital bits
            if (sub_req.start && sub_req.output_ok) begin
                drive_cnt <= drive_cnt + 1;
            end
            // skip the cycle of our own done pulse, the index advances there
            if (sub_req.start && !sub_done) begin
                if (wait_cnt == 0) begin
                    sub_done <= 1'b1;
                    sub_fail <= fail_mask[sub_req.index];
                    served   <= served + 1;
                    wait_cnt <= slow ? 3 : 0;
                end else begin
                    wait_cnt <= wait_cnt - 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [strr_pkg.sv]
package strr_pkg;

    // failure code layout, one bit per subtest
    localparam int CODE_W          = 10;
    localparam int BIT_PROG_MEM    = 0;
    localparam int BIT_WORK_MEM    = 1;
    localparam int BIT_FLASH       = 2;
    localparam int BIT_OPT_BUF     = 3;
    localparam int BIT_DIG_POT     = 4;
    localparam int BIT_LOOPBACK    = 5;
    localparam int BIT_MAX_VOLT    = 6;
    localparam int BIT_MIN_VOLT    = 7;
    localparam int BIT_QTR_OUT     = 8;
    localparam int BIT_QTR_RDBK    = 9;
    // bits that the confidence test may report
    localparam logic [9:0] CONF_MASK = 10'h01f;

    // error queue codes of power-up failures
    localparam logic [9:0] EQ_NONE       = 10'h000;
    localparam logic [9:0] EQ_CONTROLLER = 10'h191;
    localparam logic [9:0] EQ_BUS        = 10'h192;
    localparam logic [9:0] EQ_DIGITAL    = 10'h193;
    localparam logic [9:0] EQ_ANALOG     = 10'h194;

    // power-up fault indices
    localparam int PU_MEM    = 0;
    localparam int PU_BUS    = 1;
    localparam int PU_TIMER  = 2;
    localparam int PU_OPT    = 3;
    localparam int PU_REF    = 4;
    localparam int PU_DAC    = 5;
    localparam int PU_LIMIT  = 6;
    localparam int PU_AMP    = 7;
    localparam int PU_N      = 8;

    // register offsets
    localparam logic [3:0] REG_CMD      = 4'h0;
    localparam logic [3:0] REG_RESULT   = 4'h1;
    localparam logic [3:0] REG_PERIOD   = 4'h2;
    localparam logic [3:0] REG_STATUS   = 4'h3;
    localparam logic [3:0] REG_IRQ_EN   = 4'h4;
    localparam logic [3:0] REG_IRQ_CLR  = 4'h5;
    localparam logic [3:0] REG_PU_EQ    = 4'h6;
    localparam logic [3:0] REG_PU_FAULT = 4'h7;

    // command bits
    localparam int CMD_CONF = 0;
    localparam int CMD_INSTR = 1;

    // interrupt status bits
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_FAIL   = 1;
    localparam int IRQ_PU     = 2;
    localparam int IRQ_ADDR   = 3;
    localparam int IRQ_W      = 4;

    // tone timing, in ms, and cycles at 100 MHz
    localparam int CLK_MHZ     = 100;
    localparam int LONG_MS     = 300;
    localparam int SHORT_MS    = 100;
    localparam int GAP_MS      = 100;
    localparam int PAUSE_MS    = 1000;
    localparam int LONG_CYC    = LONG_MS * CLK_MHZ * 1000;
    localparam int SHORT_CYC   = SHORT_MS * CLK_MHZ * 1000;
    localparam int GAP_CYC     = GAP_MS * CLK_MHZ * 1000;
    localparam int PAUSE_CYC   = PAUSE_MS * CLK_MHZ * 1000;
    localparam logic [31:0] PERIOD_RST = 32'h0000_0000;

    // test sequencer states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_RUN     = 3'b001,
        ST_WAIT    = 3'b010,
        ST_PU_HOLD = 3'b011,
        ST_ADDR    = 3'b100
    } strr_state_type;

    // one subtest request towards the checkers
    typedef struct packed {
        logic       start;
        logic [3:0] index;
        logic       output_ok;
    } strr_subreq_type;

    // register bus request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } strr_bus_type;

endpackage

// [strr_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module strr_tb_top;
    localparam int L_P = 4;     // short tone counts keep the run small
    localparam int S_P = 2;
    localparam int G_P = 2;
    localparam int LIMIT = 20000;
    logic                       mclk;
    logic                       rstn;
    strr_pkg::strr_bus_type     bus;
    logic [31:0]                rdata;
    logic                       irq;
    strr_pkg::strr_subreq_type  sub_req;
    logic                       sub_done;
    logic                       sub_fail;
    logic [7:0]                 pu_fault;
    logic                       pu_done;
    logic [4:0]                 addr_sw;
    logic                       eq_valid;
    logic [9:0]                 eq_code;
    logic                       beep;
    logic [9:0]                 fail_mask;
    logic                       slow;
    int                         served;
    int                         drive_cnt;
    int                         error_cnt = 0;
    int                         checks_done = 0;
    int                         cyc = 0;

    strr_top #(.LONG_CYC(L_P), .SHORT_CYC(S_P), .GAP_CYC(G_P), .PAUSE_CYC(8)) dut (
        .mclk(mclk), .rstn(rstn), .bus(bus), .rdata(rdata), .irq(irq), .sub_req(sub_req),
        .sub_done(sub_done), .sub_fail(sub_fail), .pu_fault(pu_fault), .pu_done(pu_done),
        .bus_address_switch(addr_sw), .eq_valid(eq_valid), .eq_code(eq_code), .beep(beep));
    strr_checker_model chk_model (
        .mclk(mclk), .rstn(rstn), .sub_req(sub_req), .fail_mask(fail_mask), .slow(slow),
        .sub_done(sub_done), .sub_fail(sub_fail), .served(served), .drive_cnt(drive_cnt));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            $display("MISMATCH %0t timeout", $time);
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one strobe cycle; read data sampled in the cycle after it
    task automatic op(input logic [3:0] a, input logic [31:0] d, input logic w, output logic [31:0] q);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge mclk);
        bus <= '0;
        #1 q = rdata;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        op(a, d, 1'b1, q);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        op(a, 32'h0000_0000, 1'b0, q);
    endtask

    // reset, then one power-up report with the given faults
    task automatic power_up(input logic [7:0] f);
        rstn <= 1'b0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        pu_fault <= f;
        pu_done  <= 1'b1;
        @(posedge mclk);
        pu_done  <= 1'b0;
    endtask

    // length of the next tone and of the silence after it
    task automatic tone(output int h, output int l);
        h = 0;
        l = 0;
        for (int i = 0; i < 400 && beep !== 1'b1; i++) @(negedge mclk);
        while (beep === 1'b1 && h < 400) begin
            h++;
            @(negedge mclk);
        end
        while (beep !== 1'b1 && l < 400) begin
            l++;
            @(negedge mclk);
        end
    endtask

    function automatic logic [9:0] eq_exp(input int k);
        case (k)
            0, 2: return strr_pkg::EQ_CONTROLLER;
            1: return strr_pkg::EQ_BUS;
            3: return strr_pkg::EQ_DIGITAL;
            default: return strr_pkg::EQ_ANALOG;
        endcase
    endfunction

    // one bit per tone, first tone in the top bit, set for long
    function automatic logic [2:0] pat(input int k);
        case (k)
            1: return 3'h4;
            2: return 3'h6;
            3: return 3'h5;
            4: return 3'h3;
            5: return 3'h2;
            6: return 3'h1;
            default: return 3'h0;
        endcase
    endfunction

    task automatic pu_case(input int k);
        int h, l, h0, n;
        logic [31:0] q;
        logic [2:0] p;
        power_up(8'h01 << k);
        p = pat(k);
        for (int t = 2; t >= 0; t--) begin
            tone(h, l);
            if (t == 2) h0 = l;
            if (k == 0) chk(h, h0, "equal tone");
            else chk(h, p[t] ? L_P : S_P, "tone length");
            if (k != 0 && t != 0) chk(l, G_P, "tone gap");
        end
        rd(strr_pkg::REG_PU_EQ, q);
        chk(q[9:0], eq_exp(k), "queue code reg");
        rd(strr_pkg::REG_PU_FAULT, q);
        chk(q, 32'h0000_0001 << k, "fault latch");
        addr_sw <= 5'h00;
        tone(h, l);
        tone(h, l);
        chk({h[7:0], l[7:0]}, {S_P[7:0], S_P[7:0]}, "address beep");
        addr_sw <= 5'h05;
        n = 0;
        while (eq_valid !== 1'b1 && n < 60) begin
            n++;
            @(negedge mclk);
        end
        chk(eq_valid, 1'b1, "queue sent");
        chk(eq_code, eq_exp(k), "queue code");
        n = 0;
        repeat (20) begin
            @(negedge mclk);
            if (beep !== 1'b0) n++;
        end
        chk(n, 0, "beep stopped");
        rd(strr_pkg::REG_STATUS, q);
        chk(q[3:2], 2'b11, "power-up status");
        $display("power-up fault %0d done", k);
    endtask

    task automatic wait_idle();
        logic [31:0] q;
        q = 32'h0000_0001;
        for (int i = 0; i < 200 && q[0] !== 1'b0; i++) rd(strr_pkg::REG_CMD, q);
        chk(q[0], 1'b0, "run finished");
    endtask

    // commanded run; a second command while busy must be ignored
    task automatic run(input logic ext, input logic [9:0] fm, input logic en);
        logic [31:0] q;
        logic [9:0] e;
        int s0, d0;
        e = ext ? fm : (fm & strr_pkg::CONF_MASK);
        fail_mask <= fm;
        slow <= 1'($urandom_range(1, 0));
        wr(strr_pkg::REG_IRQ_CLR, 32'h0000_000f);
        wr(strr_pkg::REG_IRQ_EN, {31'h0000_0000, en});
        s0 = served;
        d0 = drive_cnt;
        wr(strr_pkg::REG_CMD, ext ? 32'h0000_0002 : 32'h0000_0001);
        wr(strr_pkg::REG_CMD, ext ? 32'h0000_0001 : 32'h0000_0002);
        wait_idle();
        rd(strr_pkg::REG_RESULT, q);
        chk(q, {22'h00_0000, e}, "result code");
        chk(served - s0, ext ? 10 : 5, "subtests run");
        rd(strr_pkg::REG_STATUS, q);
        chk(q[1:0], {e != 10'h000, 1'b1}, "status bits");
        chk(irq, en, "irq level");
        if (!ext || (fm & strr_pkg::CONF_MASK) != 10'h000) chk(drive_cnt - d0, 0, "output left alone");
        else chk(drive_cnt > d0, 1'b1, "output driven");
        wr(strr_pkg::REG_IRQ_CLR, 32'h0000_000f);
        chk(irq, 1'b0, "irq cleared");
        $display("run ext=%0d mask=%h done", ext, fm);
    endtask

    initial begin
        logic [31:0] q;
        int s0;
        void'($urandom(90751));
        bus = '0;
        pu_fault = 8'h00;
        pu_done = 1'b0;
        addr_sw = 5'h05;
        fail_mask = 10'h000;
        slow = 1'b0;
        rstn = 1'b0;
        for (int k = 0; k < strr_pkg::PU_N; k++) pu_case(k);
        power_up(8'h00);
        rd(4'hf, q);
        chk(q, 32'h0000_0000, "unmapped read");
        run(1'b0, 10'h000, 1'b1);
        run(1'b1, 10'h3ff, 1'b0);
        run(1'b1, 10'h3e0, 1'b1);
        run(1'b0, 10'h3ff, 1'b1);
        repeat (16) run(1'($urandom_range(1, 0)), 10'($urandom_range(1023, 0)), 1'($urandom_range(1, 0)));
        // periodic runs start with no command
        s0 = served;
        wr(strr_pkg::REG_PERIOD, 32'h0000_0040);
        repeat (300) @(posedge mclk);
        chk(served - s0 >= 5, 1'b1, "periodic run");
        wr(strr_pkg::REG_PERIOD, 32'h0000_0000);
        wait_idle();
        $display("periodic test done");
        results();
    end
endmodule
`default_nettype wire

// [strr_top.sv]
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - power-up, periodic and commanded test runs
// - power-up failures go to queue and beeper
// - power-up queue codes 401 to 404
// - eight coded power-up beep patterns
// - confidence test leaves output untouched
// - zero on pass, else 1..1023
// - each failing subtest sets own bit
// - all subtests always run to completion
// - bits 0-4 reported by both tests
// - bits 5-7 only in extended test
// - bits 8-9 only in extended test
// - converter/limit/amp first, then output limits
// - current-mode limit check at one volt
// - readback checked in high, low scales
// - zero address: equal beeps, wait
// - valid address: stop beep, send code
module strr_top #(
    parameter int LONG_CYC  = strr_pkg::LONG_CYC,   // long tone length
    parameter int SHORT_CYC = strr_pkg::SHORT_CYC,  // short tone length
    parameter int GAP_CYC   = strr_pkg::GAP_CYC,    // gap between tones
    parameter int PAUSE_CYC = strr_pkg::PAUSE_CYC   // pause between patterns
) (
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire strr_pkg::strr_bus_type bus,
    output logic [31:0]                rdata,
    output logic                       irq,
    output strr_pkg::strr_subreq_type  sub_req,
    input  wire logic                  sub_done,
    input  wire logic                  sub_fail,
    input  wire logic [7:0]            pu_fault,
    input  wire logic                  pu_done,
    input  wire logic [4:0]            bus_address_switch,
    output logic                       eq_valid,
    output logic [9:0]                 eq_code,
    output logic                       beep
);

    // sequencer state
    strr_pkg::strr_state_type state;
    strr_pkg::strr_state_type next_state;
    logic [3:0]  sub_idx;        // subtest under way
    logic [3:0]  last_idx;       // last subtest of this run
    logic        busy_sub;       // request outstanding
    logic [9:0]  acc;            // accumulated failures
    logic [9:0]  result;         // last completed code
    logic        instr_run;      // extended test run
    // software side
    logic [31:0] period;         // periodic interval, 0 = off
    logic [31:0] per_cnt;        // idle cycles since last run
    logic [3:0]  irq_stat;       // sticky event bits
    logic [3:0]  irq_en;         // event enables
    // power-up side
    logic [7:0]  pu_latched;     // power-up faults seen
    logic [9:0]  pu_code;        // queued power-up code
    logic        pu_pending;     // code awaits a valid address

    // decode of register strobes
    wire wr_cmd  = bus.wr && bus.addr == strr_pkg::REG_CMD;
    wire wr_per  = bus.wr && bus.addr == strr_pkg::REG_PERIOD;
    wire wr_en   = bus.wr && bus.addr == strr_pkg::REG_IRQ_EN;
    wire wr_clr  = bus.wr && bus.addr == strr_pkg::REG_IRQ_CLR;
    wire addr_zero = bus_address_switch == 5'h0_0;
    wire idle    = state == strr_pkg::ST_IDLE;
    // commands count only when idle;
    // a busy sequencer drops them
    wire go_conf  = idle && wr_cmd && bus.wdata[strr_pkg::CMD_CONF];
    wire go_instr = idle && wr_cmd && !bus.wdata[strr_pkg::CMD_CONF]
                    && bus.wdata[strr_pkg::CMD_INSTR];
    // a command beats the timer
    wire go_per  = idle && !wr_cmd && period != 32'h0000_0000
                   && per_cnt >= period;
    wire start_run = go_conf || go_instr || go_per;
    // subtest ends on its done pulse
    wire sub_fin = state == strr_pkg::ST_RUN && busy_sub && sub_done;
    wire run_end = sub_fin && sub_idx == last_idx;

    // power-up fault to queue code
    // several faults: memory or timer first, then bus, optical, analog
    function automatic logic [9:0] pu_eq(input logic [7:0] f);
        if (f[strr_pkg::PU_MEM] || f[strr_pkg::PU_TIMER])
            pu_eq = strr_pkg::EQ_CONTROLLER;
        else if (f[strr_pkg::PU_BUS])
            pu_eq = strr_pkg::EQ_BUS;
        else if (f[strr_pkg::PU_OPT])
            pu_eq = strr_pkg::EQ_DIGITAL;
        else if (f[7:4] != 4'h0)
            pu_eq = strr_pkg::EQ_ANALOG;
        else
            pu_eq = strr_pkg::EQ_NONE;
    endfunction

    // pattern per fault: 3 tones, 1 = long; bit 3 flags equal on/off
    // lowest fault picks it
    function automatic logic [3:0] pu_pat(input logic [7:0] f);
        if (f[strr_pkg::PU_MEM])        pu_pat = 4'h8;
        else if (f[strr_pkg::PU_BUS])   pu_pat = 4'h4;
        else if (f[strr_pkg::PU_TIMER]) pu_pat = 4'h6;
        else if (f[strr_pkg::PU_OPT])   pu_pat = 4'h5;
        else if (f[strr_pkg::PU_REF])   pu_pat = 4'h3;
        else if (f[strr_pkg::PU_DAC])   pu_pat = 4'h2;
        else if (f[strr_pkg::PU_LIMIT]) pu_pat = 4'h1;
        else                            pu_pat = 4'h0;
    endfunction

    // sequencer next state
    // power-up comes first; runs
    // start only from idle
    always_comb begin
        next_state = state;
        case (state)
            strr_pkg::ST_IDLE: begin
                if (pu_pending && addr_zero)
                    next_state = strr_pkg::ST_ADDR;
                else if (start_run)
                    next_state = strr_pkg::ST_RUN;
            end
            strr_pkg::ST_RUN: begin
                if (run_end)
                    next_state = strr_pkg::ST_IDLE;
            end
            strr_pkg::ST_WAIT: begin
                if (pu_done)
                    next_state = (pu_fault != 8'h00) ? strr_pkg::ST_PU_HOLD
                                                     : strr_pkg::ST_IDLE;
            end
            strr_pkg::ST_PU_HOLD: begin
                if (addr_zero)
                    next_state = strr_pkg::ST_ADDR;
            end
            strr_pkg::ST_ADDR: begin
                if (!addr_zero)
                    next_state = strr_pkg::ST_IDLE;
            end
            default: next_state = strr_pkg::ST_IDLE;
        endcase
    end

    // state register; reset waits for power-up checks
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) state <= strr_pkg::ST_WAIT;
        else       state <= next_state;
    end

    // subtest walk; instrument order puts converter/limit/amp
    // (index 0..4 internal) before output-driving ones 5..9
    // acc clears at each start
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sub_idx   <= 4'h0;
            last_idx  <= 4'h0;
            busy_sub  <= 1'b0;
            acc       <= 10'h000;
            instr_run <= 1'b0;
        end else if (start_run && idle && !(pu_pending && addr_zero)) begin
            sub_idx   <= 4'h0;
            last_idx  <= go_instr ? 4'h9 : 4'h4;
            instr_run <= go_instr;
            acc       <= 10'h000;
            busy_sub  <= 1'b1;
        end else if (sub_fin) begin
            if (sub_fail)
                acc[sub_idx] <= 1'b1;
            sub_idx  <= sub_idx + 4'h1;
            busy_sub <= !run_end;
        end
    end

    // output may be driven only after internal checks pass;
    // indices 0..4 never touch the supply output, so
    // confidence runs and the first half of an extended
    // run leave it alone
    wire int_ok  = acc[4:0] == 5'h00;                     // internal bits clean
    wire out_idx = sub_idx >= 4'(strr_pkg::BIT_LOOPBACK);
    assign sub_req = '{start:     busy_sub && state == strr_pkg::ST_RUN,
                       index:     sub_idx,
                       output_ok: instr_run && out_idx && int_ok};

    // final code; confidence runs mask extended bits
    // last failure merged here, as acc
    // takes it only at this edge
    wire [9:0] final_acc = acc | (sub_fail ? 10'h001 << sub_idx : 10'h000);
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) result <= 10'h000;
        else if (run_end)
            result <= instr_run ? final_acc
                                : final_acc & strr_pkg::CONF_MASK;
    end

    // periodic timer
    // a zero period only blocks go_per
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)          per_cnt <= 32'h0000_0000;
        else if (start_run) per_cnt <= 32'h0000_0000;
        else if (idle)      per_cnt <= per_cnt + 32'h0000_0001;
    end

    // software registers
    // reads have no side effects
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            period <= strr_pkg::PERIOD_RST;
            irq_en <= 4'h0;
        end else begin
            if (wr_per) period <= bus.wdata;
            if (wr_en)  irq_en <= bus.wdata[3:0];
        end
    end

    // power-up capture and pending queue entry
    // entry waits for a valid address
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pu_latched <= 8'h00;
            pu_code    <= 10'h000;
            pu_pending <= 1'b0;
        end else if (state == strr_pkg::ST_WAIT && pu_done) begin
            pu_latched <= pu_fault;
            pu_code    <= pu_eq(pu_fault);
            pu_pending <= pu_fault != 8'h00;
        end else if (state == strr_pkg::ST_ADDR && !addr_zero) begin
            pu_pending <= 1'b0;
        end
    end

    // queue output pulse
    // one pulse per address entry
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            eq_valid <= 1'b0;
            eq_code  <= 10'h000;
        end else begin
            eq_valid <= state == strr_pkg::ST_ADDR && !addr_zero;
            if (state == strr_pkg::ST_ADDR && !addr_zero)
                eq_code <= pu_code;
        end
    end

    // sticky status; a set in the clearing cycle survives
    wire [3:0] irq_set = {state == strr_pkg::ST_ADDR && !addr_zero,
                          state == strr_pkg::ST_WAIT && pu_done && pu_fault != 8'h00,
                          run_end && (final_acc != 10'h000),
                          run_end};
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) irq_stat <= 4'h0;
        else       irq_stat <= (irq_stat & ~(wr_clr ? bus.wdata[3:0] : 4'h0)) | irq_set;
    end
    assign irq = (irq_stat & irq_en) != 4'h0;

    // read mux
    // zero outside read cycles, so
    // stale data never lingers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) rdata <= 32'h0000_0000;
        else if (bus.rd) begin
            case (bus.addr)
                strr_pkg::REG_CMD:      rdata <= {31'h0, !idle};
                strr_pkg::REG_RESULT:   rdata <= {22'h0, result};
                strr_pkg::REG_PERIOD:   rdata <= period;
                strr_pkg::REG_STATUS:   rdata <= {28'h0, irq_stat};
                strr_pkg::REG_IRQ_EN:   rdata <= {28'h0, irq_en};
                strr_pkg::REG_PU_EQ:    rdata <= {22'h0, pu_code};
                strr_pkg::REG_PU_FAULT: rdata <= {24'h0, pu_latched};
                default:                rdata <= 32'h0000_0000;
            endcase
        end else rdata <= 32'h0000_0000;
    end

    // beeper: tone index 0..2, on phase then gap; equal mode alternates
    // counts restart when silent, so
    // each pattern opens in full, save the equal one entered from ST_PU_HOLD
    logic [31:0] bcnt;
    logic [1:0]  tone;
    logic        on_ph;
    wire [3:0] pat = addr_zero && state == strr_pkg::ST_ADDR ? 4'h8 : pu_pat(pu_latched);
    wire beeping = state == strr_pkg::ST_PU_HOLD || state == strr_pkg::ST_ADDR;
    wire cur_long = pat[2 - tone];
    wire [31:0] on_len  = pat[3] ? SHORT_CYC : (cur_long ? LONG_CYC : SHORT_CYC);
    wire [31:0] off_len = pat[3] ? SHORT_CYC : (tone == 2'd2 ? PAUSE_CYC : GAP_CYC);
    wire ph_end = bcnt + 32'h0000_0001 >= (on_ph ? on_len : off_len);
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bcnt  <= 32'h0000_0000;
            tone  <= 2'd0;
            on_ph <= 1'b1;
        end else if (!beeping) begin
            bcnt  <= 32'h0000_0000;
            tone  <= 2'd0;
            on_ph <= 1'b1;
        end else if (ph_end) begin
            bcnt  <= 32'h0000_0000;
            on_ph <= !on_ph;
            if (!on_ph) tone <= (tone == 2'd2 || pat[3]) ? 2'd0 : tone + 2'd1;
        end else bcnt <= bcnt + 32'h0000_0001;
    end
    assign beep = beeping && on_ph;

    // assertions
    // silent once entry is out
    no_beep_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
        idle |-> !beep) else $error("beep while idle");

    // no extended confidence bits
    conf_mask_a: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(run_end) && !instr_run |=> result[9:5] == 5'h00) else $error("extended bits in confidence");

    // failures never cut a run
    run_all_a: assert property (@(posedge mclk) disable iff (!rstn)
        sub_fin && sub_fail && !run_end |=> state == strr_pkg::ST_RUN) else $error("run aborted");

    // only power-up codes leave
    eq_range_a: assert property (@(posedge mclk) disable iff (!rstn)
        eq_valid |-> eq_code >= strr_pkg::EQ_CONTROLLER && eq_code <= strr_pkg::EQ_ANALOG)
        else $error("bad queue code");

    // zero switches keep waiting
    addr_wait_a: assert property (@(posedge mclk) disable iff (!rstn)
        state == strr_pkg::ST_ADDR && addr_zero |=> state == strr_pkg::ST_ADDR) else $error("left wait");

    // confidence keeps output off
    out_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
        sub_req.output_ok |-> instr_run) else $error("output driven by confidence");

    // failing subtest keeps bit
    fail_bit_a: assert property (@(posedge mclk) disable iff (!rstn)
        sub_fin && sub_fail && !run_end |=> acc[$past(sub_idx)]) else $error("fail bit lost");

    // enabled status raises irq
    irq_lvl_a: assert property (@(posedge mclk) disable iff (!rstn)
        (irq_stat & irq_en) != 4'h0 |-> irq) else $error("irq missing");

    // busy commands are dropped
    busy_cmd_a: assert property (@(posedge mclk) disable iff (!rstn)
        wr_cmd && !idle |=> last_idx == $past(last_idx)) else $error("busy command taken");

    // confidence covers bits 0..4
    conf_len_a: assert property (@(posedge mclk) disable iff (!rstn)
        go_conf && !pu_pending |=> last_idx == 4'h4) else $error("confidence length");

    // extended covers bits 0..9
    instr_len_a: assert property (@(posedge mclk) disable iff (!rstn)
        go_instr && !pu_pending |=> last_idx == 4'h9) else $error("extended length");

    // optical alone: digital code
    pu_code_a: assert property (@(posedge mclk) disable iff (!rstn)
        state == strr_pkg::ST_WAIT && pu_done && pu_fault[3:0] == 4'h8
        |=> pu_code == strr_pkg::EQ_DIGITAL) else $error("optical code");

    // output after clean internals
    out_order_a: assert property (@(posedge mclk) disable iff (!rstn)
        sub_req.output_ok |-> sub_req.index >= 4'h5 && acc[4:0] == 5'h00) else $error("output too early");

    // one queue pulse per entry
    eq_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
        eq_valid |=> !eq_valid) else $error("queue pulse repeated");

    // clear never beats done
    stat_set_a: assert property (@(posedge mclk) disable iff (!rstn)
        run_end |=> irq_stat[strr_pkg::IRQ_DONE]) else $error("done bit lost");

    // clean run returns zero
    pass_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
        run_end && final_acc == 10'h000 |=> result == 10'h000) else $error("pass not zero");

endmodule

`default_nettype wire
